// file: pir_top.sv
// peripheral interrupt flags, line combining and core interrupt controller
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pir_top (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // register bus
  input  wire pir_pkg::pir_apb_req_t apbReq,
  output pir_pkg::pir_apb_rsp_t  apbRsp,
  // peripheral conditions, indexed by line
  input  wire pir_pkg::pir_evt_t periphEvt,
  input  wire logic              nmiSrc,
  // processor side
  input  wire logic              coreAck,
  output pir_pkg::pir_line_t     lineReq,
  output pir_pkg::pir_line_t     pendOut,
  output logic                   actValid,
  output logic [4:0]             actLine,
  output logic                   nmiOut,
  output logic                   irqOut
);

  pir_pkg::pir_state_t q;
  pir_pkg::pir_state_t d;
  pir_pkg::pir_arb_t   arb;

  logic [11:0]          off;
  logic [31:0]          wm;
  logic [7:0]           wm8;
  logic                 isPer;
  logic [4:0]           pIdx;
  logic [1:0]           sub;
  logic                 commit;
  logic                 wrHit;
  logic                 flagClrHit;
  logic                 enSetHit;
  logic                 enClrHit;
  logic                 prioWr0;
  logic [1:0]           prioField0;
  pir_pkg::pir_line_t   reqNow;
  pir_pkg::pir_line_t   pendEn;

  // byte lanes to bit mask
  function automatic logic [31:0] strbMask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction

  // pack four priority fields into one word
  function automatic logic [31:0] prioWord(input pir_pkg::pir_prio_t p,
                                           input logic [2:0] n);
    logic [31:0] w;
    int          l;
    w = '0;
    for (int b = 0; b < 4; b++) begin
      l = int'(n) * 4 + b;
      if (l < pir_pkg::NLINE) begin
        w[b*8 + pir_pkg::PRIO_LSB +: pir_pkg::PW] = p[l];
      end
    end
    return w;
  endfunction

  // address decode
  always_comb begin
    logic [11:0] rel;
    rel    = apbReq.paddr - pir_pkg::OFF_PER;
    off    = apbReq.paddr;
    isPer  = (off >= pir_pkg::OFF_PER) &&
             (rel < 12'(pir_pkg::NLINE) * pir_pkg::PER_STRIDE) &&
             (off[1:0] == 2'h0);
    pIdx   = rel[8:4];
    sub    = rel[3:2];
    wm     = apbReq.pwdata & strbMask(apbReq.pstrb);
    wm8    = wm[7:0];
  end

  assign commit     = (q.st == pir_pkg::ST_RESP) && apbReq.psel && apbReq.penable;
  assign wrHit      = commit && apbReq.pwrite && !q.rsp.pslverr;
  assign flagClrHit = wrHit && isPer && (sub == pir_pkg::SUB_FLAG);
  assign enSetHit   = wrHit && isPer && (sub == pir_pkg::SUB_ENSET);
  assign enClrHit   = wrHit && isPer && (sub == pir_pkg::SUB_ENCLR);
  assign prioWr0    = wrHit && (off == pir_pkg::OFF_PRIO) && apbReq.pstrb[0];
  assign prioField0 = apbReq.pwdata[pir_pkg::PRIO_LSB +: pir_pkg::PW];

  // per peripheral OR of enabled flags
  always_comb begin
    for (int p = 0; p < pir_pkg::NLINE; p++) begin
      reqNow[p] = |(q.flag[p] & q.en[p]);
    end
  end

  assign pendEn = q.pend & q.lineEn;

  always_comb begin
    logic        hit;
    logic [31:0] rd;
    logic [4:0]  pl;
    pir_pkg::pir_line_t wl;
    pir_pkg::pir_line_t ackClr;
    pir_pkg::pir_line_t pSet;
    pir_pkg::pir_line_t pClr;
    pir_pkg::pir_line_t eSet;
    pir_pkg::pir_line_t eClr;
    pir_pkg::pir_line_t sClr;
    pir_pkg::pir_line_t rise;
    d      = q;
    hit    = 1'b0;
    rd     = '0;
    pl     = '0;
    wl     = wm[pir_pkg::NLINE-1:0];
    ackClr = '0;
    pSet   = '0;
    pClr   = '0;
    eSet   = '0;
    eClr   = '0;
    sClr   = '0;
    rise   = '0;

    // read mux and decode hit
    if (isPer) begin
      hit = (sub != 2'h3);
      case (sub)
        pir_pkg::SUB_FLAG:  rd = {24'h000000, q.flag[pIdx]};
        pir_pkg::SUB_ENSET: rd = {24'h000000, q.en[pIdx]};
        pir_pkg::SUB_ENCLR: rd = {24'h000000, q.en[pIdx]};
        default:            rd = '0;
      endcase
    end else begin
      hit = 1'b1;
      case (off)
        pir_pkg::OFF_PEND_SET,
        pir_pkg::OFF_PEND_CLR: rd = 32'(q.pend);
        pir_pkg::OFF_LEN_SET,
        pir_pkg::OFF_LEN_CLR:  rd = 32'(q.lineEn);
        pir_pkg::OFF_STAT:     rd = 32'(q.stat);
        pir_pkg::OFF_MASK:     rd = 32'(q.mask);
        default: begin
          if (off >= pir_pkg::OFF_PRIO && off < pir_pkg::OFF_PRIO + 12'(pir_pkg::NPRIO * 4) &&
              off[1:0] == 2'h0) begin
            rd = prioWord(q.prio, off[4:2]);
          end else begin
            hit = 1'b0;
          end
        end
      endcase
    end

    // bus handshake, one wait cycle
    case (q.st)
      pir_pkg::ST_IDLE: begin
        d.rsp.pready = 1'b0;
        if (apbReq.psel && apbReq.penable) begin
          d.st          = pir_pkg::ST_RESP;
          d.rsp.pready  = 1'b1;
          d.rsp.pslverr = !hit;
          d.rsp.prdata  = apbReq.pwrite ? 32'h00000000 : rd;
        end
      end
      pir_pkg::ST_RESP: begin
        d.st          = pir_pkg::ST_IDLE;
        d.rsp.pready  = 1'b0;
        d.rsp.pslverr = 1'b0;
      end
      default: begin
        d.st         = pir_pkg::ST_IDLE;
        d.rsp.pready = 1'b0;
      end
    endcase

    // core controller writes
    if (wrHit && !isPer) begin
      case (off)
        pir_pkg::OFF_PEND_SET: pSet = wl;
        pir_pkg::OFF_PEND_CLR: pClr = wl;
        pir_pkg::OFF_LEN_SET:  eSet = wl;
        pir_pkg::OFF_LEN_CLR:  eClr = wl;
        pir_pkg::OFF_STAT:     sClr = wl;
        pir_pkg::OFF_MASK:     d.mask = wl;
        default: begin
          for (int b = 0; b < 4; b++) begin
            pl = 5'(int'(off[4:2]) * 4 + b);
            if (apbReq.pstrb[b] && int'(pl) < pir_pkg::NLINE) begin
              d.prio[pl] = apbReq.pwdata[b*8 + pir_pkg::PRIO_LSB +: pir_pkg::PW];
            end
          end
        end
      endcase
    end

    // peripheral flags and enables
    for (int p = 0; p < pir_pkg::NLINE; p++) begin
      // flag cleared only by a one written
      if (flagClrHit && pIdx == 5'(p)) begin
        d.flag[p] = q.flag[p] & ~wm8;
      end
      d.flag[p] = d.flag[p] | periphEvt[p];
      if (enSetHit && pIdx == 5'(p)) begin
        d.en[p] = q.en[p] | wm8;
      end
      if (enClrHit && pIdx == 5'(p)) begin
        d.en[p] = q.en[p] & ~wm8;
      end
    end

    // one ORed request per peripheral line
    d.req = reqNow;

    // acknowledge retires the active line
    if (coreAck && arb.valid) begin
      ackClr[arb.line] = 1'b1;
    end

    // request sets pending, set wins over clear
    d.pend   = (q.pend & ~pClr & ~ackClr) | pSet | q.req;
    d.lineEn = (q.lineEn | eSet) & ~eClr;

    // sticky status on request rise, write one clears
    rise   = d.req & ~q.req;
    d.stat = (q.stat & ~sClr) | rise;
    d.irq  = |(d.stat & d.mask);

    d.nmi = nmiSrc;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= pir_pkg::PIR_RST;
    end else begin
      q <= d;
    end
  end

  // only pending and enabled lines compete
  pir_arb u_arb (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cand    (pendEn),
    .prio    (q.prio),
    .sel     (arb)
  );

  assign apbRsp   = q.rsp;
  assign lineReq  = q.req;
  assign pendOut  = q.pend;
  assign actValid = arb.valid;
  assign actLine  = arb.line;
  assign nmiOut   = q.nmi;
  assign irqOut   = q.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_flagSet;
    (periphEvt != '0) |=> ((q.flag & $past(periphEvt)) == $past(periphEvt));
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("flag not set by condition");

  property p_enSet;
    enSetHit |=> ((q.en[$past(pIdx)] & $past(wm8)) == $past(wm8));
  endproperty
  a_enSet: assert property (p_enSet) else $error("enable set write lost");

  property p_enClr;
    enClrHit |=> ((q.en[$past(pIdx)] & $past(wm8)) == 8'h00);
  endproperty
  a_enClr: assert property (p_enClr) else $error("enable clear write lost");

  property p_reqOnlyEn;
    1'b1 |=> ((lineReq & ~$past(reqNow)) == '0);
  endproperty
  a_reqOnlyEn: assert property (p_reqOnlyEn) else $error("request without flag and enable");

  property p_orLine;
    (reqNow != '0) |=> (lineReq == $past(reqNow));
  endproperty
  a_orLine: assert property (p_orLine) else $error("line request not ORed");

  property p_pend;
    (lineReq != '0) |=> ((pendOut & $past(lineReq)) == $past(lineReq));
  endproperty
  a_pend: assert property (p_pend) else $error("request did not set pending");

  property p_act;
    (pendEn == '0) |=> !actValid;
  endproperty
  a_act: assert property (p_act) else $error("activation without enabled pending");

  property p_prio;
    prioWr0 |=> (q.prio[0] == $past(prioField0));
  endproperty
  a_prio: assert property (p_prio) else $error("priority field not written");

  property p_nmi;
    nmiSrc |=> nmiOut ##0 (lineReq[pir_pkg::LINE_EXT] == $past(reqNow[pir_pkg::LINE_EXT]));
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not routed");

  property p_mapWdog;
    reqNow[pir_pkg::LINE_WDOG] |=> lineReq[pir_pkg::LINE_WDOG] ##1 pendOut[pir_pkg::LINE_WDOG];
  endproperty
  a_mapWdog: assert property (p_mapWdog) else $error("watchdog line wrong");

  property p_mapSer;
    reqNow[pir_pkg::LINE_SER5] |=> lineReq[pir_pkg::LINE_SER5];
  endproperty
  a_mapSer: assert property (p_mapSer) else $error("serial line wrong");

  property p_mapTc;
    reqNow[pir_pkg::LINE_TMR7] |=> lineReq[pir_pkg::LINE_TMR7];
  endproperty
  a_mapTc: assert property (p_mapTc) else $error("timer line wrong");

  property p_mapTouch;
    reqNow[pir_pkg::LINE_TOUCH] |=> lineReq[pir_pkg::LINE_TOUCH];
  endproperty
  a_mapTouch: assert property (p_mapTouch) else $error("touch line wrong");

  property p_flagHold;
    !flagClrHit |=> ((q.flag & $past(q.flag)) == $past(q.flag));
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("flag dropped without clear");

  property p_covIrq;
    (reqNow != '0) ##1 (lineReq != '0) ##[1:3] actValid;
  endproperty
  c_covIrq: cover property (p_covIrq);

  property p_covErr;
    apbRsp.pready && apbRsp.pslverr;
  endproperty
  c_covErr: cover property (p_covErr);

  property p_covAck;
    actValid && coreAck;
  endproperty
  c_covAck: cover property (p_covAck);

endmodule

// file: pir_pkg.sv
// constants and types of the peripheral interrupt routing block
package pir_pkg;

  localparam int NLINE = 25;
  localparam int NSRC  = 8;
  localparam int PW    = 2;
  localparam int NPRIO = 8;
  localparam int PRIO_LSB = 6;

  localparam logic [4:0] LINE_POWER = 5'h00;
  localparam logic [4:0] LINE_SYS   = 5'h01;
  localparam logic [4:0] LINE_WDOG  = 5'h02;
  localparam logic [4:0] LINE_RTC   = 5'h03;
  localparam logic [4:0] LINE_EXT   = 5'h04;
  localparam logic [4:0] LINE_NVM   = 5'h05;
  localparam logic [4:0] LINE_EVS   = 5'h06;
  localparam logic [4:0] LINE_SER0  = 5'h07;
  localparam logic [4:0] LINE_SER5  = 5'h0C;
  localparam logic [4:0] LINE_TMR0  = 5'h0D;
  localparam logic [4:0] LINE_TMR7  = 5'h14;
  localparam logic [4:0] LINE_ADC   = 5'h15;
  localparam logic [4:0] LINE_ACMP  = 5'h16;
  localparam logic [4:0] LINE_DAC   = 5'h17;
  localparam logic [4:0] LINE_TOUCH = 5'h18;

  // core controller register offsets
  localparam logic [11:0] OFF_PEND_SET = 12'h000;
  localparam logic [11:0] OFF_PEND_CLR = 12'h004;
  localparam logic [11:0] OFF_LEN_SET  = 12'h008;
  localparam logic [11:0] OFF_LEN_CLR  = 12'h00C;
  localparam logic [11:0] OFF_STAT     = 12'h010;
  localparam logic [11:0] OFF_MASK     = 12'h014;
  localparam logic [11:0] OFF_PRIO     = 12'h020;
  // peripheral windows: base + line * stride, then flag / set / clear words
  localparam logic [11:0] OFF_PER      = 12'h100;
  localparam logic [11:0] PER_STRIDE   = 12'h010;
  localparam logic [1:0]  SUB_FLAG     = 2'h0;
  localparam logic [1:0]  SUB_ENSET    = 2'h1;
  localparam logic [1:0]  SUB_ENCLR    = 2'h2;

  typedef logic [NLINE-1:0][NSRC-1:0] pir_evt_t;
  typedef logic [NLINE-1:0][PW-1:0]   pir_prio_t;
  typedef logic [NLINE-1:0]           pir_line_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } pir_st_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } pir_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pir_apb_rsp_t;

  typedef struct packed {
    pir_st_t      st;
    pir_apb_rsp_t rsp;
    pir_evt_t     flag;
    pir_evt_t     en;
    pir_line_t    req;
    pir_line_t    pend;
    pir_line_t    lineEn;
    pir_line_t    stat;
    pir_line_t    mask;
    pir_prio_t    prio;
    logic         irq;
    logic         nmi;
  } pir_state_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] line;
  } pir_arb_t;

  localparam pir_state_t PIR_RST = '{st: ST_IDLE, default: '0};

endpackage

// file: pir_arb.sv
// priority selection of the active line
`timescale 1ns/1ps
module pir_arb (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // candidates
  input  wire pir_pkg::pir_line_t cand,
  input  wire pir_pkg::pir_prio_t prio,
  // selection
  output pir_pkg::pir_arb_t    sel
);

  pir_pkg::pir_arb_t q;
  pir_pkg::pir_arb_t d;

  // lowest priority value wins, lowest line on a tie
  always_comb begin
    logic [pir_pkg::PW-1:0] best;
    best = '1;
    d    = '0;
    for (int i = 0; i < pir_pkg::NLINE; i++) begin
      if (cand[i] && (!d.valid || prio[i] < best)) begin
        d.valid = 1'b1;
        d.line  = 5'(i);
        best    = prio[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sel = q;

endmodule

// file: pir_core_model.sv
// processor core model that takes the active line and retires it
`timescale 1ns/1ps
module pir_core_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // controller outputs
  input  wire logic       actValid,
  input  wire logic [4:0] actLine,
  // behaviour control
  input  wire logic       ackEn,
  input  wire logic [3:0] ackDelay,
  // acknowledge
  output logic            coreAck,
  output logic [4:0]      ackLine,
  output int              ackCnt
);
  logic [3:0] waitCnt;

  // waits ackDelay cycles of stable activation, then retires the line
  always_ff @(posedge clk_sys) begin
    coreAck <= 1'b0;
    if (!rst_n) begin
      waitCnt <= 4'h0;
      ackLine <= 5'h00;
      ackCnt  <= 0;
    end else if (!actValid || !ackEn) begin
      waitCnt <= 4'h0;
    end else if (waitCnt == ackDelay) begin
      coreAck <= 1'b1;
      ackLine <= actLine;
      ackCnt  <= ackCnt + 1;
      waitCnt <= 4'h0;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// file: pir_tb.sv
// self-checking bench for the interrupt routing block
`timescale 1ns/1ps
module testbench;
  logic                  clk_sys = 1'b0;
  logic                  rst_n;
  pir_pkg::pir_apb_req_t apbReq;
  pir_pkg::pir_apb_rsp_t apbRsp;
  pir_pkg::pir_evt_t     periphEvt;
  logic                  nmiSrc;
  logic                  coreAck;
  pir_pkg::pir_line_t    lineReq;
  pir_pkg::pir_line_t    pendOut;
  logic                  actValid;
  logic [4:0]            actLine;
  logic                  nmiOut;
  logic                  irqOut;
  logic                  ackEn;
  logic [3:0]            ackDelay;
  logic [4:0]            ackLine;
  int                    ackCnt;
  int                    err_count = 0;
  int                    n_tests   = 0;
  int                    seed      = 32'hF5E5C686;
  int                    p;
  int                    s;
  logic [7:0]            mFlag [25] = '{default: '0};
  logic [7:0]            mEn [25]   = '{default: '0};
  logic [31:0]           mPr [8]    = '{default: '0};
  logic [24:0]           mPend = '0;
  logic [24:0]           mLen  = '0;
  logic [24:0]           mStat = '0;
  logic [24:0]           mMask = '0;
  logic [24:0]           mPrev = '0;
  logic [24:0]           mReq;

  always #12.5 clk_sys = ~clk_sys;

  pir_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .periphEvt(periphEvt),
               .nmiSrc(nmiSrc), .coreAck(coreAck), .lineReq(lineReq), .pendOut(pendOut), .actValid(actValid),
               .actLine(actLine), .nmiOut(nmiOut), .irqOut(irqOut));

  pir_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .actValid(actValid), .actLine(actLine), .ackEn(ackEn),
                       .ackDelay(ackDelay), .coreAck(coreAck), .ackLine(ackLine), .ackCnt(ackCnt));

  // reference model of requests, pending and status
  always_comb begin
    for (int i = 0; i < 25; i++) begin
      mReq[i] = |(mFlag[i] & mEn[i]);
    end
  end

  always @(posedge clk_sys) begin
    if (coreAck === 1'b1 && !mReq[ackLine]) begin
      mPend[ackLine] = 1'b0;
    end
    mPend = mPend | mReq;
    mStat = mStat | (mReq & ~mPrev);
    mPrev = mReq;
  end

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= w;
    apbReq.paddr   <= a;
    apbReq.pwdata  <= d;
    apbReq.pstrb   <= 4'hF;
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (apbRsp.pready !== 1'b1);
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  function automatic logic [31:0] ex(logic [11:0] a);
    logic [31:0] r;
    int          q;
    r = '0;
    q = (a - 12'h100) >> 4;
    if (a >= 12'h100) r = (a[3:2] == 2'h0) ? mFlag[q] : mEn[q];
    else if (a == 12'h000 || a == 12'h004) r = mPend;
    else if (a == 12'h008 || a == 12'h00C) r = mLen;
    else if (a == 12'h010) r = mStat;
    else if (a == 12'h014) r = mMask;
    else r = mPr[(a - 12'h020) >> 2];
    return r;
  endfunction

  task automatic rd(logic [11:0] a);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("read %h", a), ex(a), r);
    chk($sformatf("error %h", a), 32'h0, e);
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    int          q;
    apb(1'b1, a, d, r, e);
    q = (a - 12'h100) >> 4;
    if (a >= 12'h100) begin
      if (a[3:2] == 2'h0) mFlag[q] &= ~d[7:0];
      else if (a[3:2] == 2'h1) mEn[q] |= d[7:0];
      else mEn[q] &= ~d[7:0];
    end
    else if (a == 12'h000) mPend |= d[24:0];
    else if (a == 12'h004) mPend &= ~d[24:0];
    else if (a == 12'h008) mLen |= d[24:0];
    else if (a == 12'h00C) mLen &= ~d[24:0];
    else if (a == 12'h010) mStat &= ~d[24:0];
    else if (a == 12'h014) mMask = d[24:0];
    else begin
      for (q = 0; q < 4; q++) begin
        if (int'((a - 12'h020) >> 2) * 4 + q < 25) mPr[(a - 12'h020) >> 2][8*q+6 +: 2] = d[8*q+6 +: 2];
      end
    end
  endtask

  task automatic ev(int l, int b);
    @(posedge clk_sys);
    periphEvt[l][b] <= 1'b1;
    mFlag[l][b] = 1'b1;
    @(posedge clk_sys);
    periphEvt[l][b] <= 1'b0;
  endtask

  function automatic logic [11:0] win(int l);
    return 12'(256 + 16 * l);
  endfunction

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    rst_n = 1'b0;
    apbReq = '0;
    periphEvt = '0;
    nmiSrc = 1'b0;
    ackEn = 1'b0;
    ackDelay = 4'h8;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(12'h000);
    rd(12'h010);
    rd(win(24));
    apb(1'b1, 12'h10C, 32'hFFFFFFFF, r, e);
    chk("slverr", 32'h1, e);
    apb(1'b0, 12'h10C, 32'h0, r, e);
    chk("unmapped read", 32'h0, r);
    for (p = 0; p < 25; p++) begin
      s = $random(seed) & 7;
      wr(win(p) + 12'h4, ($random(seed) & 32'hFF) | (1 << s));
      rd(win(p) + 12'h4);
      ev(p, s);
      repeat (3) @(posedge clk_sys);
      chk("lineReq", mReq, lineReq);
      rd(win(p));
      wr(win(p) + 12'h8, $random(seed));
      rd(win(p) + 12'h8);
      repeat (3) @(posedge clk_sys);
      chk("lineReq", mReq, lineReq);
      rd(win(p));
      wr(win(p), 32'hFF);
    end
    rd(12'h010);
    wr(12'h014, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk("irqOut", |(mStat & mMask), irqOut);
    wr(12'h014, $random(seed) | 1);
    repeat (3) @(posedge clk_sys);
    chk("irqOut", |(mStat & mMask), irqOut);
    wr(12'h010, 32'h01FFFFFF);
    repeat (3) @(posedge clk_sys);
    chk("irqOut", |(mStat & mMask), irqOut);
    rd(12'h004);
    chk("pendOut", mPend, pendOut);
    chk("actValid", 32'h0, actValid);
    wr(12'h004, 32'h01FFFFFF);
    rd(12'h000);
    wr(12'h020, 32'hC0000000);
    wr(12'h034, 32'h00000040);
    rd(12'h020);
    rd(12'h034);
    wr(12'h000, 32'h00100008);
    wr(12'h008, 32'h00100008);
    repeat (4) @(posedge clk_sys);
    chk("actValid", 32'h1, actValid);
    chk("actLine", 32'h14, actLine);
    ackEn <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("ackCnt", 32'h2, ackCnt);
    chk("ackLine", 32'h03, ackLine);
    rd(12'h000);
    ackDelay <= 4'h2;
    wr(12'h000, 32'h01000000);
    wr(12'h008, 32'h01000000);
    repeat (12) @(posedge clk_sys);
    chk("ackLine", 32'h18, ackLine);
    chk("ackCnt", 32'h3, ackCnt);
    wr(12'h00C, 32'h01FFFFFF);
    rd(12'h008);
    nmiSrc <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("nmiOut", 32'h1, nmiOut);
    chk("lineReq", mReq, lineReq);
    nmiSrc <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("nmiOut", 32'h0, nmiOut);
    print_verdict();
  end
endmodule
